// >>> rtl/scai_core.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - an accepted command is cleared to zero; completion shows in flags or state.
// - open moves state per protocol: TCP 0x13, UDP 0x22, raw 0x02, closed none.
// - listen, TCP only, moves TCP-opened to waiting-server.
// - while waiting, success gives session up plus bit 0; failure bit 3, released.
// - connect, TCP only, sends SYN; success gives session up plus bit 0.
// - connect fails to released on resolution timeout, TCP timeout or RST.
// - teardown ends released on FIN/ACK, or on timeout with bit 3.
// - an RST from the peer releases a listening, connecting, connected or closing TCP socket.
// - close releases the socket at once with no packet exchange.
// - send transmits all data between the transmit pointers.
// - keep-alive, TCP only; no answer before timeout ends session with bit 3.
// - receive acknowledge completes receive handling using the read pointer.
// - a flag sets only on its event while its mask bit is one.
// - bits 7 to 5 read zero; bit 4 sets when a send finishes.
// - bit 3 sets on a resolution timeout or a retransmit timeout.
// - bit 2 sets when data arrives while session up or close-wait, or in UDP or raw mode.
// - bit 1 sets when a FIN or FIN/ACK arrives.
// - bit 0 sets once when the session becomes established.
// - protocol field: 0 closed, 1 TCP, 2 UDP, 4 raw frame.
module scai_core
	import scai_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// register port
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	// events reported by the protocol engine
	input  wire logic       connectOk,
	input  wire logic       finReceived,
	input  wire logic       finAckReceived,
	input  wire logic       rstReceived,
	input  wire logic       resolutionTimeout,
	input  wire logic       retransmitTimeout,
	input  wire logic       dataReceived,
	input  wire logic       sendDone,
	// requests to the protocol engine, one-cycle pulses except teardownPassive, held while in close-wait
	output logic            openReq,
	output logic            listenReq,
	output logic            connectReq,
	output logic            teardownReq,
	output logic            teardownPassive,
	output logic            sendReq,
	output logic            sendNoArpReq,
	output logic            keepAliveReq,
	output logic            rxAckReq,
	// state seen by the engine
	output logic [3:0]      protocolMode,
	output logic [7:0]      socketState
);
	import scai_pkg::*;

	logic [7:0]            socket_command_reg;
	logic [7:0]            socket_protocol_reg;
	logic [7:0]            socket_event_mask;
	logic [FLAG_COUNT-1:0] socket_event_flags;
	scai_state_t           state;
	scai_state_t           next_state;
	logic [FLAG_COUNT-1:0] event_vec;
	logic [3:0]            proto;
	logic                  accept;
	logic                  cmdOk;

	function automatic logic [7:0] stateCode(input scai_state_t s);
		unique case (s)
			stateReleased:      return SR_RELEASED;
			stateTcpOpened:     return SR_TCP_OPENED;
			stateWaitingServer: return SR_WAITING;
			stateSynSent:       return SR_SYN_SENT;
			stateSessionUp:     return SR_SESSION_UP;
			stateCloseWait:     return SR_CLOSE_WAIT;
			stateFinWait:       return SR_FIN_WAIT;
			stateLastAck:       return SR_LAST_ACK;
			stateDatagramOpen:  return SR_DGRAM_OPEN;
			stateRawOpen:       return SR_RAW_OPEN;
		endcase
	endfunction

	// whether a command does anything in the current mode and state
	function automatic logic cmdValid(input logic [7:0] c,
		input logic [3:0] p, input scai_state_t s);
		logic tcp;
		logic up;
		tcp = (p == PROTO_TCP);
		up  = (s == stateSessionUp) || (s == stateCloseWait);
		unique case (c)
			CMD_OPEN:       return 1'b1;
			CMD_CLOSE:      return 1'b1;
			CMD_LISTEN:     return tcp && (s == stateTcpOpened);
			CMD_CONNECT:    return tcp && (s == stateTcpOpened);
			CMD_TEARDOWN:   return tcp && up;
			CMD_KEEPALIVE:  return tcp && (s == stateSessionUp);
			CMD_SEND:       return (tcp && up) || s == stateDatagramOpen
				|| s == stateRawOpen;
			CMD_SEND_NOARP: return p == PROTO_UDP
				&& s == stateDatagramOpen;
			CMD_RX_ACK:     return s != stateReleased
				&& s != stateTcpOpened;
			default:        return 1'b0;
		endcase
	endfunction

	function automatic logic tcpLive(input scai_state_t s);
		return s == stateWaitingServer || s == stateSynSent
			|| s == stateSessionUp || s == stateCloseWait
			|| s == stateFinWait || s == stateLastAck;
	endfunction

	assign proto        = socket_protocol_reg[PROTO_MSB:PROTO_LSB];
	assign accept       = (socket_command_reg != RESET_COMMAND);
	assign cmdOk        = accept && cmdValid(socket_command_reg, proto, state);
	assign protocolMode = proto;
	assign socketState  = stateCode(state);

	// a write in the accepting cycle replaces the byte, so nothing is dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			socket_command_reg <= RESET_COMMAND;
		end else if (regWrite && regAddr == ADDR_COMMAND) begin
			socket_command_reg <= regWdata;
		end else begin
			socket_command_reg <= RESET_COMMAND;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			socket_protocol_reg <= RESET_PROTOCOL;
			socket_event_mask   <= RESET_MASK;
		end else if (regWrite) begin
			if (regAddr == ADDR_PROTOCOL) begin
				socket_protocol_reg <= regWdata;
			end
			if (regAddr == ADDR_MASK) begin
				socket_event_mask <= regWdata;
			end
		end
	end

	always_comb begin
		next_state = state;
		event_vec  = '0;
		unique case (state)
			stateWaitingServer: begin
				if (connectOk) begin
					next_state = stateSessionUp;
					event_vec[FLAG_SESSION] = 1'b1;
				end else if (retransmitTimeout) begin
					next_state = stateReleased;
					event_vec[FLAG_TIMEOUT] = 1'b1;
				end
			end
			stateSynSent: begin
				if (connectOk) begin
					next_state = stateSessionUp;
					event_vec[FLAG_SESSION] = 1'b1;
				end else if (resolutionTimeout || retransmitTimeout) begin
					next_state = stateReleased;
					event_vec[FLAG_TIMEOUT] = 1'b1;
				end
			end
			stateSessionUp: begin
				if (finReceived) begin
					next_state = stateCloseWait;
					event_vec[FLAG_TEARDOWN_CMD] = 1'b1;
				end else if (retransmitTimeout) begin
					next_state = stateReleased;
					event_vec[FLAG_TIMEOUT] = 1'b1;
				end
			end
			stateCloseWait: begin
				if (retransmitTimeout) begin
					next_state = stateReleased;
					event_vec[FLAG_TIMEOUT] = 1'b1;
				end
			end
			stateFinWait, stateLastAck: begin
				if (finAckReceived || finReceived) begin
					next_state = stateReleased;
					event_vec[FLAG_TEARDOWN_CMD] = 1'b1;
				end else if (retransmitTimeout) begin
					next_state = stateReleased;
					event_vec[FLAG_TIMEOUT] = 1'b1;
				end
			end
			stateReleased, stateTcpOpened, stateDatagramOpen,
			stateRawOpen: begin
			end
		endcase
		// a failed resolution for a datagram send still raises the timeout
		if (resolutionTimeout && state == stateDatagramOpen) begin
			event_vec[FLAG_TIMEOUT] = 1'b1;
		end
		if (dataReceived && (state == stateSessionUp
			|| state == stateCloseWait || state == stateDatagramOpen
			|| state == stateRawOpen)) begin
			event_vec[FLAG_RX_ACK_CMD] = 1'b1;
		end
		if (sendDone) begin
			event_vec[FLAG_SENDOK] = 1'b1;
		end
		if (cmdOk) begin
			unique case (socket_command_reg)
				CMD_OPEN: begin
					unique case (proto)
						PROTO_TCP: next_state = stateTcpOpened;
						PROTO_UDP: next_state = stateDatagramOpen;
						PROTO_RAW: next_state = stateRawOpen;
						default:   next_state = state;
					endcase
				end
				CMD_LISTEN:  next_state = stateWaitingServer;
				CMD_CONNECT: next_state = stateSynSent;
				CMD_TEARDOWN: begin
					if (state == stateCloseWait) begin
						next_state = stateLastAck;
					end else begin
						next_state = stateFinWait;
					end
				end
				CMD_CLOSE:   next_state = stateReleased;
				default:     next_state = next_state;
			endcase
		end
		// reset from the peer beats everything, a same-cycle local close included
		if (rstReceived && tcpLive(state)) begin
			next_state = stateReleased;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= stateReleased;
		end else begin
			state <= next_state;
		end
	end

	// set wins over a same-cycle write-one clear
	always_ff @(posedge clk) begin
		if (rst) begin
			socket_event_flags <= RESET_FLAGS[FLAG_COUNT-1:0];
		end else begin
			socket_event_flags <= (socket_event_flags
				& ~((regWrite && regAddr == ADDR_FLAGS)
				? regWdata[FLAG_COUNT-1:0] : '0))
				| (event_vec & socket_event_mask[FLAG_COUNT-1:0]);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			openReq         <= 1'b0;
			listenReq       <= 1'b0;
			connectReq      <= 1'b0;
			teardownReq     <= 1'b0;
			teardownPassive <= 1'b0;
			sendReq         <= 1'b0;
			sendNoArpReq    <= 1'b0;
			keepAliveReq    <= 1'b0;
			rxAckReq        <= 1'b0;
		end else begin
			openReq      <= cmdOk && socket_command_reg == CMD_OPEN
				&& proto != PROTO_CLOSED;
			listenReq    <= cmdOk && socket_command_reg == CMD_LISTEN;
			connectReq   <= cmdOk && socket_command_reg == CMD_CONNECT;
			teardownReq  <= cmdOk && socket_command_reg == CMD_TEARDOWN;
			teardownPassive <= state == stateCloseWait;
			sendReq      <= cmdOk && socket_command_reg == CMD_SEND;
			sendNoArpReq <= cmdOk
				&& socket_command_reg == CMD_SEND_NOARP;
			keepAliveReq <= cmdOk
				&& socket_command_reg == CMD_KEEPALIVE;
			rxAckReq     <= cmdOk && socket_command_reg == CMD_RX_ACK;
		end
	end

	// reserved flag bits read as zero; the command byte reads back live
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdata <= READ_UNMAPPED;
		end else if (regRead) begin
			unique case (regAddr)
				ADDR_PROTOCOL: regRdata <= socket_protocol_reg;
				ADDR_COMMAND:  regRdata <= socket_command_reg;
				ADDR_FLAGS:    regRdata <= {{(8-FLAG_COUNT){1'b0}},
					socket_event_flags};
				ADDR_STATE:    regRdata <= socketState;
				ADDR_MASK:     regRdata <= socket_event_mask;
				default:       regRdata <= READ_UNMAPPED;
			endcase
		end
	end

	chk_cmd_self_clear: assert property (@(posedge clk) disable iff (rst)
		accept && !regWrite |=> socket_command_reg == RESET_COMMAND)
		else $error("command byte not cleared after acceptance");

	chk_open_tcp_state: assert property (@(posedge clk) disable iff (rst)
		accept && socket_command_reg == CMD_OPEN && proto == PROTO_TCP
		&& !(rstReceived && tcpLive(state))
		|=> socketState == SR_TCP_OPENED)
		else $error("open in tcp mode did not reach opened state");

	chk_listen_move: assert property (@(posedge clk) disable iff (rst)
		state == stateTcpOpened && socket_command_reg == CMD_LISTEN
		&& proto == PROTO_TCP |=> state == stateWaitingServer && listenReq)
		else $error("listen did not enter waiting state");

	chk_listen_connect: assert property (@(posedge clk) disable iff (rst)
		state == stateWaitingServer && connectOk && !accept && !rstReceived
		&& socket_event_mask[FLAG_SESSION]
		|=> state == stateSessionUp && socket_event_flags[FLAG_SESSION])
		else $error("server connect did not establish with flag");

	chk_close_now: assert property (@(posedge clk) disable iff (rst)
		accept && socket_command_reg == CMD_CLOSE |=> state == stateReleased)
		else $error("close did not release the socket");

	chk_peer_reset: assert property (@(posedge clk) disable iff (rst)
		rstReceived && tcpLive(state) |=> socketState == SR_RELEASED)
		else $error("peer reset did not release the socket");

	chk_mask_gate: assert property (@(posedge clk) disable iff (rst)
		((socket_event_flags & ~$past(socket_event_flags))
		& ~$past(socket_event_mask[FLAG_COUNT-1:0])) == '0)
		else $error("flag set while masked");

	chk_send_flag: assert property (@(posedge clk) disable iff (rst)
		sendDone && socket_event_mask[FLAG_SENDOK]
		|=> socket_event_flags[FLAG_SENDOK])
		else $error("send completion flag not set");

	chk_invalid_quiet: assert property (@(posedge clk) disable iff (rst)
		accept && !cmdOk && !rstReceived && !connectOk && !finReceived
		&& !finAckReceived && !retransmitTimeout && !resolutionTimeout
		|=> $stable(state) && !listenReq && !connectReq && !sendReq)
		else $error("invalid command changed the socket");

endmodule

`default_nettype wire

// >>> rtl/scai_pkg.sv
package scai_pkg;

	// register indices; the byte address equals the index
	localparam logic [7:0] ADDR_PROTOCOL  = 8'h00;
	localparam logic [7:0] ADDR_COMMAND   = 8'h01;
	localparam logic [7:0] ADDR_FLAGS     = 8'h02;
	localparam logic [7:0] ADDR_STATE     = 8'h03;
	localparam logic [7:0] ADDR_MASK      = 8'h20;

	localparam logic [7:0] RESET_COMMAND  = 8'h00;
	localparam logic [7:0] RESET_FLAGS    = 8'h00;
	localparam logic [7:0] RESET_PROTOCOL = 8'h00;
	localparam logic [7:0] RESET_MASK     = 8'h00;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;

	// command codes
	localparam logic [7:0] CMD_OPEN       = 8'h01;
	localparam logic [7:0] CMD_LISTEN     = 8'h02;
	localparam logic [7:0] CMD_CONNECT    = 8'h04;
	localparam logic [7:0] CMD_TEARDOWN   = 8'h08;
	localparam logic [7:0] CMD_CLOSE      = 8'h10;
	localparam logic [7:0] CMD_SEND       = 8'h20;
	localparam logic [7:0] CMD_SEND_NOARP = 8'h21;
	localparam logic [7:0] CMD_KEEPALIVE  = 8'h22;
	localparam logic [7:0] CMD_RX_ACK     = 8'h40;

	// protocol field, low nibble of the protocol register
	localparam int         PROTO_LSB      = 0;
	localparam int         PROTO_MSB      = 3;
	localparam logic [3:0] PROTO_CLOSED   = 4'h0;
	localparam logic [3:0] PROTO_TCP      = 4'h1;
	localparam logic [3:0] PROTO_UDP      = 4'h2;
	localparam logic [3:0] PROTO_RAW      = 4'h4;

	// state codes as software reads them
	localparam logic [7:0] SR_RELEASED    = 8'h00;
	localparam logic [7:0] SR_RAW_OPEN    = 8'h02;
	localparam logic [7:0] SR_TCP_OPENED  = 8'h13;
	localparam logic [7:0] SR_WAITING     = 8'h14;
	localparam logic [7:0] SR_SYN_SENT    = 8'h15;
	localparam logic [7:0] SR_SESSION_UP  = 8'h17;
	localparam logic [7:0] SR_FIN_WAIT    = 8'h18;
	localparam logic [7:0] SR_CLOSE_WAIT  = 8'h1C;
	localparam logic [7:0] SR_LAST_ACK    = 8'h1D;
	localparam logic [7:0] SR_DGRAM_OPEN  = 8'h22;

	// flag bit positions
	localparam int FLAG_SESSION = 0;
	localparam int FLAG_TEARDOWN_CMD  = 1;
	localparam int FLAG_RX_ACK_CMD    = 2;
	localparam int FLAG_TIMEOUT = 3;
	localparam int FLAG_SENDOK  = 4;
	localparam int FLAG_COUNT   = 5;

	typedef enum logic [3:0] {
		stateReleased, stateTcpOpened, stateWaitingServer, stateSynSent,
		stateSessionUp, stateCloseWait, stateFinWait, stateLastAck,
		stateDatagramOpen, stateRawOpen
	} scai_state_t;

endpackage

// >>> tb/scai_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module scai_peer_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// behaviour picked by the bench
	input  wire logic [1:0] mode,
	input  wire logic       slow,
	input  wire logic [7:0] poke,
	// requests from the socket
	input  wire logic       listenReq,
	input  wire logic       connectReq,
	input  wire logic       teardownReq,
	input  wire logic       sendReq,
	input  wire logic       sendNoArpReq,
	input  wire logic       keepAliveReq,
	// events back to the socket
	output logic            connectOk,
	output logic            finReceived,
	output logic            finAckReceived,
	output logic            rstReceived,
	output logic            resolutionTimeout,
	output logic            retransmitTimeout,
	output logic            dataReceived,
	output logic            sendDone
);
	logic [7:0] evt;
	logic [7:0] pend;
	logic [7:0] resp;
	logic [2:0] cnt;
	logic [7:0] hs;
	// mode 0 accepts, 1 never answers, 2 resets, 3 cannot resolve
	always_comb begin
		case (mode)
			2'h0: hs = 8'h01;
			2'h1: hs = 8'h20;
			2'h2: hs = 8'h08;
			default: hs = 8'h10;
		endcase
		resp = 8'h00;
		if (connectReq || listenReq)
			resp = hs;
		if (teardownReq)
			resp = 8'h04;
		if (sendReq || sendNoArpReq)
			resp = 8'h80;
		if (keepAliveReq && mode == 2'h1)
			resp = 8'h20;
	end
	// one answer in flight; a request during the wait is dropped
	always_ff @(posedge clk) begin
		evt <= 8'h00;
		if (rst) begin
			cnt  <= 3'h0;
			pend <= 8'h00;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h1)
				evt <= pend;
		end else if (resp != 8'h00) begin
			pend <= resp;
			cnt  <= slow ? 3'h6 : 3'h1;
		end
	end
	assign connectOk         = evt[0] | poke[0];
	assign finReceived       = evt[1] | poke[1];
	assign finAckReceived    = evt[2] | poke[2];
	assign rstReceived       = evt[3] | poke[3];
	assign resolutionTimeout = evt[4] | poke[4];
	assign retransmitTimeout = evt[5] | poke[5];
	assign dataReceived      = evt[6] | poke[6];
	assign sendDone          = evt[7] | poke[7];
endmodule
`default_nettype wire

// >>> tb/tb_socket_command_and_interrupt.sv
`timescale 1ns/1ps
`default_nettype none
module tb_socket_command_and_interrupt;
	import scai_pkg::*;
	logic       clk, rst, regWrite, regRead, slow;
	logic [7:0] regAddr, regWdata, regRdata, poke, rdv;
	logic [1:0] mode;
	logic       connectOk, finReceived, finAckReceived, rstReceived;
	logic       resolutionTimeout, retransmitTimeout, dataReceived;
	logic       sendDone, openReq, listenReq, connectReq, teardownReq;
	logic       teardownPassive, sendReq, sendNoArpReq, keepAliveReq;
	logic       rxAckReq;
	logic [3:0] protocolMode;
	logic [7:0] socketState;
	int         fails, samples_checked, acks, opens;

	scai_core DUT (.clk, .rst, .regWrite, .regRead, .regAddr, .regWdata,
		.regRdata, .connectOk, .finReceived, .finAckReceived, .rstReceived,
		.resolutionTimeout, .retransmitTimeout, .dataReceived, .sendDone,
		.openReq, .listenReq, .connectReq, .teardownReq, .teardownPassive,
		.sendReq, .sendNoArpReq, .keepAliveReq, .rxAckReq, .protocolMode,
		.socketState);
	scai_peer_model peer (.clk, .rst, .mode, .slow, .poke, .listenReq,
		.connectReq, .teardownReq, .sendReq, .sendNoArpReq, .keepAliveReq,
		.connectOk, .finReceived, .finAckReceived, .rstReceived,
		.resolutionTimeout, .retransmitTimeout, .dataReceived, .sendDone);

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rxAckReq === 1'b1)
			acks++;
		if (openReq === 1'b1)
			opens++;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 rdv = regRdata;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// polls up to tries reads; a bounded wait that runs out ends the run
	task automatic see(input logic [7:0] a, input logic [7:0] e,
		input int tries);
		for (int i = 0; i < tries; i++) begin
			rd(a);
			if (rdv === e)
				break;
		end
		chk(rdv, e);
		if (rdv !== e && tries > 1)
			wrap_up();
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(ADDR_COMMAND, c);
		see(ADDR_COMMAND, 8'h00, 1);
	endtask
	task automatic open(input logic [3:0] p);
		wr(ADDR_PROTOCOL, {4'h0, p});
		cmd(CMD_OPEN);
	endtask
	task automatic pulse(input logic [7:0] b);
		@(posedge clk);
		poke <= b;
		@(posedge clk);
		poke <= 8'h00;
	endtask

	task automatic t_reset();
		see(ADDR_COMMAND, RESET_COMMAND, 1);
		see(ADDR_FLAGS, RESET_FLAGS, 1);
		see(ADDR_STATE, SR_RELEASED, 1);
		wr(8'h50, 8'hA5);
		see(8'h50, READ_UNMAPPED, 1);
		$display("test reset done");
	endtask
	task automatic t_open();
		logic [3:0] pm [4];
		logic [7:0] ps [4];
		pm = '{PROTO_CLOSED, PROTO_TCP, PROTO_UDP, PROTO_RAW};
		ps = '{SR_RELEASED, SR_TCP_OPENED, SR_DGRAM_OPEN, SR_RAW_OPEN};
		for (int i = 0; i < 4; i++) begin
			open(pm[i]);
			see(ADDR_STATE, ps[i], 1);
			chk({4'h0, protocolMode}, {4'h0, pm[i]});
			cmd(CMD_CLOSE);
			see(ADDR_STATE, SR_RELEASED, 1);
		end
		chk(8'(opens), 8'h03);
		$display("test open done");
	endtask
	task automatic t_client();
		wr(ADDR_MASK, 8'h1F);
		open(PROTO_TCP);
		cmd(CMD_CONNECT);
		see(ADDR_STATE, SR_SESSION_UP, 30);
		see(ADDR_FLAGS, 8'h01, 1);
		wr(ADDR_FLAGS, 8'h01);
		see(ADDR_FLAGS, 8'h00, 1);
		for (int m = 1; m < 4; m++) begin
			mode = m[1:0];
			open(PROTO_TCP);
			cmd(CMD_CONNECT);
			see(ADDR_STATE, SR_RELEASED, 30);
			if (m != 2)
				see(ADDR_FLAGS, 8'h08, 1);
			wr(ADDR_FLAGS, 8'hFF);
		end
		mode = 2'h0;
		$display("test client done");
	endtask
	task automatic t_server();
		slow = 1'b1;
		open(PROTO_TCP);
		cmd(CMD_LISTEN);
		see(ADDR_STATE, SR_WAITING, 1);
		see(ADDR_STATE, SR_SESSION_UP, 30);
		see(ADDR_FLAGS, 8'h01, 1);
		wr(ADDR_FLAGS, 8'h01);
		cmd(CMD_TEARDOWN);
		see(ADDR_STATE, SR_FIN_WAIT, 1);
		see(ADDR_STATE, SR_RELEASED, 30);
		see(ADDR_FLAGS, 8'h02, 1);
		wr(ADDR_FLAGS, 8'h02);
		open(PROTO_TCP);
		cmd(CMD_LISTEN);
		pulse(8'h20);
		see(ADDR_STATE, SR_RELEASED, 1);
		see(ADDR_FLAGS, 8'h08, 1);
		wr(ADDR_FLAGS, 8'h08);
		slow = 1'b0;
		$display("test server done");
	endtask
	task automatic t_udp();
		wr(ADDR_MASK, 8'h00);
		open(PROTO_UDP);
		pulse(8'h40);
		see(ADDR_FLAGS, 8'h00, 1);
		wr(ADDR_MASK, 8'h04);
		pulse(8'h40);
		see(ADDR_FLAGS, 8'h04, 1);
		wr(ADDR_FLAGS, 8'hFF);
		wr(ADDR_MASK, 8'h1F);
		cmd(CMD_SEND);
		see(ADDR_FLAGS, 8'h10, 30);
		wr(ADDR_FLAGS, 8'h10);
		cmd(CMD_SEND_NOARP);
		see(ADDR_FLAGS, 8'h10, 30);
		wr(ADDR_FLAGS, 8'h10);
		cmd(CMD_LISTEN);
		see(ADDR_STATE, SR_DGRAM_OPEN, 1);
		cmd(CMD_CLOSE);
		$display("test udp done");
	endtask
	task automatic t_live();
		open(PROTO_TCP);
		cmd(CMD_CONNECT);
		see(ADDR_STATE, SR_SESSION_UP, 30);
		wr(ADDR_FLAGS, 8'hFF);
		cmd(CMD_SEND_NOARP);
		cmd(CMD_RX_ACK);
		see(ADDR_FLAGS, 8'h00, 1);
		see(ADDR_STATE, SR_SESSION_UP, 1);
		chk(8'(acks), 8'h01);
		pulse(8'h08);
		see(ADDR_STATE, SR_RELEASED, 1);
		open(PROTO_TCP);
		cmd(CMD_CONNECT);
		see(ADDR_STATE, SR_SESSION_UP, 30);
		wr(ADDR_FLAGS, 8'hFF);
		mode = 2'h1;
		cmd(CMD_KEEPALIVE);
		see(ADDR_STATE, SR_RELEASED, 30);
		see(ADDR_FLAGS, 8'h08, 1);
		mode = 2'h0;
		open(PROTO_TCP);
		cmd(CMD_CONNECT);
		see(ADDR_STATE, SR_SESSION_UP, 30);
		// slow answer keeps last-ack visible long enough to read
		slow = 1'b1;
		pulse(8'h02);
		see(ADDR_STATE, SR_CLOSE_WAIT, 1);
		chk({7'h00, teardownPassive}, 8'h01);
		cmd(CMD_TEARDOWN);
		see(ADDR_STATE, SR_LAST_ACK, 1);
		see(ADDR_STATE, SR_RELEASED, 30);
		slow = 1'b0;
		$display("test live done");
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		poke = 8'h00;
		mode = 2'h0;
		slow = 1'b0;
		fails = 0;
		samples_checked = 0;
		acks = 0;
		opens = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_open();
		t_client();
		t_server();
		t_udp();
		t_live();
		wrap_up();
	end
endmodule
`default_nettype wire
